// ---- logic/oar_core.sv ----
/*
  Operand addressing and single-instruction repeat control: forms
  direct, indirect, immediate and register operands, keeps the
  auxiliary registers, their pointer and the page pointer, and runs
  the repeat counter with interrupt masking. Registers are reachable
  over APB. Assumes fetch presents one decoded instruction per cycle
  and holds it while fetch_hold_o is high; data memory answers a read
  combinationally in the cycle the registered request is shown.
*/
module oar_core
  import oar_pkg::*;
(
  input  wire logic        clk_i,        // Core clock
  input  wire logic        rst_n_i,      // Synchronous reset, low
  input  wire oar_insn_s   insn_i,       // Decoded instruction
  input  wire logic [15:0] data_rdata_i, // Data memory read word
  output oar_mem_s         mem_o,        // Data memory request
  output oar_opnd_s        opnd_o,       // Immediate operand
  output logic [1:0]       insn_len_o,   // Words taken by the insn
  output logic             iter_o,       // Pipelined iteration pulse
  output logic             fetch_hold_o, // Keep current instruction
  output logic             irq_mask_o,   // Mask every interrupt
  input  wire logic        psel_i,       // APB select
  input  wire logic        penable_i,    // APB enable
  input  wire logic        pwrite_i,     // APB write
  input  wire logic [7:0]  paddr_i,      // APB byte address
  input  wire logic [31:0] pwdata_i,     // APB write data
  output logic [31:0]      prdata_o,     // APB read data
  output logic             pready_o,     // APB ready
  output logic             pslverr_o     // APB unmapped address or status write
);

  logic [15:0] ar_r [N_AR]; // Auxiliary registers
  logic [15:0] ar_nxt [N_AR];
  logic [2:0] arp_r; // Aux register pointer
  logic [2:0] arp_nxt;
  logic [8:0] dp_r; // Data page pointer
  logic [8:0] dp_nxt;
  logic [15:0] cnt_r; // Repeat count register
  logic [15:0] cnt_nxt;
  oar_state_e state_r; // Repeat sequencer
  oar_state_e state_nxt;
  oar_mem_s mem_r; // Output registers
  oar_mem_s mem_nxt;
  oar_opnd_s opnd_r;
  oar_opnd_s opnd_nxt;
  logic [1:0] len_r;
  logic [1:0] len_nxt;
  logic iter_r;
  logic iter_nxt;
  logic hold_r;
  logic hold_nxt;
  logic mask_r;
  logic mask_nxt;
  logic [31:0] prdata_r; // APB answer registers
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  logic accept; // Instruction consumed this cycle
  logic is_mem; // Instruction has a data operand
  logic is_ind; // Data operand is indirect
  logic [15:0] cur_ar; // Selected auxiliary register
  logic [15:0] upd_ar; // Its updated value
  oar_ind_e ind_mode; // Effective indirect mode
  logic apb_setup; // APB setup phase
  logic apb_wr; // APB write completes
  logic ar_hit; // Address falls on an aux register
  logic [2:0] ar_sel; // Aux register picked by address

  // Instruction classification
  always_comb begin
    accept = insn_i.valid && (state_r != S_LOAD);
    is_mem = (insn_i.kind == K_MEM) || (insn_i.kind == K_REPEATABLE) ||
             (insn_i.kind == K_RPT_MEM);
    is_ind = insn_i.word[AMODE_BIT];
    ind_mode = is_ind ? oar_ind_e'(insn_i.word[IND_HI:IND_LO]) : IND_NONE;
    cur_ar = ar_r[arp_r];
  end

  oar_ar_update u_ar_update (
    .mode_i (ind_mode),
    .ar_i   (cur_ar),
    .idx_i  (ar_r[0]),
    .ar_o   (upd_ar)
  );

  // APB decode; zero wait states, ready raised for the access phase
  always_comb begin
    apb_setup = psel_i && !penable_i;
    apb_wr = psel_i && penable_i && pwrite_i && pready_r;
    ar_hit = (paddr_i >= OFS_AR0) && (paddr_i <= OFS_AR7) && (paddr_i[1:0] == 2'h0);
    ar_sel = paddr_i[4:2];
  end

  // Pointer, page and register file next values
  always_comb begin
    dp_nxt = dp_r;
    arp_nxt = arp_r;
    for (int i = 0; i < N_AR; i++) begin
      ar_nxt[i] = ar_r[i];
    end
    // Software writes first, so a same-cycle instruction update wins
    if (apb_wr && !pslverr_r) begin
      if (paddr_i == OFS_DP) begin
        dp_nxt = pwdata_i[8:0];
      end else if (paddr_i == OFS_ARP) begin
        arp_nxt = pwdata_i[2:0];
      end else if (ar_hit) begin
        ar_nxt[ar_sel] = pwdata_i[15:0];
      end
    end
    if (accept && is_mem && is_ind) begin
      ar_nxt[arp_r] = upd_ar;
      if (insn_i.word[ARP_LD_BIT]) begin
        arp_nxt = insn_i.word[ARP_HI:0];
      end
    end
  end

  // Operand forming towards memory and execution
  always_comb begin
    mem_nxt = '0;
    opnd_nxt = '0;
    len_nxt = len_r;
    iter_nxt = 1'b0;
    if (accept) begin
      len_nxt = LEN_ONE;
      if (is_mem) begin
        mem_nxt.rd = 1'b1;
        if (is_ind) begin
          // Address is the register before its update
          mem_nxt.addr = cur_ar;
        end else begin
          mem_nxt.addr = {dp_r, insn_i.word[DMA_HI:0]};
        end
      end else if (insn_i.kind == K_SHORT) begin
        opnd_nxt.valid = 1'b1;
        opnd_nxt.value = {8'h00, insn_i.word[IMM_HI:0]};
      end else if (insn_i.kind == K_LONG) begin
        opnd_nxt.valid = 1'b1;
        opnd_nxt.value = insn_i.word2;
        len_nxt = LEN_TWO;
      end
      // register form, no address or immediate is driven
      iter_nxt = (state_r == S_REPEAT) && (insn_i.kind == K_REPEATABLE);
    end
  end

  // Repeat sequencer and counter
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      S_IDLE: begin
        if (accept && insn_i.kind == K_RPT_SHORT) begin
          cnt_nxt = {8'h00, insn_i.word[IMM_HI:0]};
          state_nxt = S_REPEAT;
        end else if (accept && insn_i.kind == K_RPT_MEM) begin
          state_nxt = S_LOAD;
        end
      end
      S_LOAD: begin
        cnt_nxt = data_rdata_i;
        state_nxt = S_REPEAT;
      end
      S_REPEAT: begin
        if (accept) begin
          if (cnt_r == 16'h0000 || insn_i.kind != K_REPEATABLE) begin
            cnt_nxt = 16'h0000;
            state_nxt = S_IDLE;
          end else begin
            cnt_nxt = 16'(cnt_r - 16'h0001);
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    hold_nxt = (state_nxt != S_IDLE);
    mask_nxt = (state_nxt != S_IDLE);
  end

  // APB read data and error for the next access phase
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt = apb_setup;
    if (apb_setup) begin
      if (paddr_i == OFS_DP) begin
        prdata_nxt = {23'h000000, dp_r};
      end else if (paddr_i == OFS_ARP) begin
        prdata_nxt = {29'h00000000, arp_r};
      end else if (paddr_i == OFS_RPT) begin
        prdata_nxt = {15'h0000, state_r != S_IDLE, cnt_r};
        pslverr_nxt = pwrite_i;
      end else if (ar_hit) begin
        prdata_nxt = {16'h0000, ar_r[ar_sel]};
      end else begin
        // Unmapped: error answer, reads as zero
        pslverr_nxt = 1'b1;
      end
    end
  end

  // State registers; reset is synchronous
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dp_r <= DP_RST;
      arp_r <= ARP_RST;
      for (int i = 0; i < N_AR; i++) begin
        ar_r[i] <= AR_RST;
      end
      cnt_r <= CNT_RST;
      state_r <= S_IDLE;
      mem_r <= '0;
      opnd_r <= '0;
      len_r <= LEN_ONE;
      iter_r <= 1'b0;
      hold_r <= 1'b0;
      mask_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      dp_r <= dp_nxt;
      arp_r <= arp_nxt;
      ar_r <= ar_nxt;
      cnt_r <= cnt_nxt;
      state_r <= state_nxt;
      mem_r <= mem_nxt;
      opnd_r <= opnd_nxt;
      len_r <= len_nxt;
      iter_r <= iter_nxt;
      hold_r <= hold_nxt;
      mask_r <= mask_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign mem_o = mem_r;
  assign opnd_o = opnd_r;
  assign insn_len_o = len_r;
  assign iter_o = iter_r;
  assign fetch_hold_o = hold_r;
  assign irq_mask_o = mask_r;
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;

  // Checks of the addressing and repeat behaviour
  sequence s_rpt_short;
    accept && state_r == S_IDLE && insn_i.kind == K_RPT_SHORT;
  endsequence
  sequence s_last_iter;
    accept && state_r == S_REPEAT && cnt_r == 16'h0000;
  endsequence

  property p_cnt_reset;
    @(posedge clk_i) !rst_n_i |=> cnt_r == 16'h0000 && !irq_mask_o;
  endproperty
  a_cnt_reset: assert property (p_cnt_reset) else $error("count not cleared");

  property p_short_load;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_rpt_short |=> cnt_r == {8'h00, $past(insn_i.word[IMM_HI:0])} && irq_mask_o;
  endproperty
  a_short_load: assert property (p_short_load) else $error("bad short count");

  property p_mem_load;
    @(posedge clk_i) disable iff (!rst_n_i)
      state_r == S_LOAD |-> mem_o.rd ##1 cnt_r == $past(data_rdata_i);
  endproperty
  a_mem_load: assert property (p_mem_load) else $error("bad memory count");

  property p_mask;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_r != S_IDLE) |-> irq_mask_o && fetch_hold_o;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupts open in loop");

  property p_loop_end;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_last_iter |=> !fetch_hold_o && !irq_mask_o && state_r == S_IDLE;
  endproperty
  a_loop_end: assert property (p_loop_end) else $error("loop did not end");

  property p_decrement;
    @(posedge clk_i) disable iff (!rst_n_i)
      accept && state_r == S_REPEAT && cnt_r != 16'h0000 && insn_i.kind == K_REPEATABLE
      |=> cnt_r == 16'($past(cnt_r) - 16'h0001) && iter_o;
  endproperty
  a_decrement: assert property (p_decrement) else $error("bad decrement");

  property p_direct;
    @(posedge clk_i) disable iff (!rst_n_i)
      accept && is_mem && !is_ind |=> mem_o.rd &&
      mem_o.addr == {$past(dp_r), $past(insn_i.word[DMA_HI:0])};
  endproperty
  a_direct: assert property (p_direct) else $error("bad direct address");

  property p_inc;
    @(posedge clk_i) disable iff (!rst_n_i)
      accept && is_mem && ind_mode == IND_INC && !insn_i.word[ARP_LD_BIT]
      |=> ar_r[$past(arp_r)] == 16'($past(cur_ar) + 16'h0001) && mem_o.addr == $past(cur_ar);
  endproperty
  a_inc: assert property (p_inc) else $error("bad post increment");

  property p_long;
    @(posedge clk_i) disable iff (!rst_n_i)
      accept && insn_i.kind == K_LONG |=> insn_len_o == LEN_TWO && opnd_o.valid &&
      opnd_o.value == $past(insn_i.word2);
  endproperty
  a_long: assert property (p_long) else $error("bad long immediate");

  property p_short;
    @(posedge clk_i) disable iff (!rst_n_i)
      accept && insn_i.kind == K_SHORT |=> insn_len_o == LEN_ONE &&
      opnd_o.value == {8'h00, $past(insn_i.word[IMM_HI:0])};
  endproperty
  a_short: assert property (p_short) else $error("bad short immediate");

  property p_reg;
    @(posedge clk_i) disable iff (!rst_n_i)
      accept && insn_i.kind == K_REG |=> !mem_o.rd && !opnd_o.valid;
  endproperty
  a_reg: assert property (p_reg) else $error("register form drove operand");

endmodule : oar_core

// ---- logic/oar_pkg.sv ----
/*
  Package for the operand addressing and repeat block: the decoded
  instruction carrier, the field positions inside an instruction word,
  the register map of the APB slave and the reset values.
  Assumes one core clock and a synchronous active-low reset.
*/
package oar_pkg;

  // Operand form of the instruction presented by the fetch stage
  typedef enum logic [2:0] {
    K_REG        = 3'b000, // Register operand, no address
    K_MEM        = 3'b001, // Direct or indirect data operand
    K_SHORT      = 3'b010, // Short immediate in the word
    K_LONG       = 3'b011, // Long immediate in second word
    K_REPEATABLE = 3'b100, // Multicycle, pipelined under repeat
    K_RPT_MEM    = 3'b101, // Repeat, count from data memory
    K_RPT_SHORT  = 3'b110, // Repeat, count from 8-bit field
    K_SPARE      = 3'b111  // Treated as register operand
  } oar_kind_e;

  // Indirect update modes, code 3'b111 is reserved
  typedef enum logic [2:0] {
    IND_NONE   = 3'b000, // Plain indirect, no change
    IND_INC    = 3'b001, // Post increment
    IND_DEC    = 3'b010, // Post decrement
    IND_ADD0   = 3'b011, // Post add index register
    IND_SUB0   = 3'b100, // Post subtract index register
    IND_BR_INC = 3'b101, // Bit-reversed add of index
    IND_BR_DEC = 3'b110, // Bit-reversed subtract of index
    IND_RSVD   = 3'b111  // Reserved, acts as no change
  } oar_ind_e;

  // Repeat sequencer states
  typedef enum logic [1:0] {
    S_IDLE   = 2'b00, // Normal sequential execution
    S_LOAD   = 2'b01, // Waiting for the count word
    S_REPEAT = 2'b10  // Loop running
  } oar_state_e;

  // Instruction as handed over by fetch
  typedef struct packed {
    logic      valid; // Instruction present this cycle
    oar_kind_e kind;  // Operand form
    logic [15:0] word;  // First instruction word
    logic [15:0] word2; // Second word, long immediate
  } oar_insn_s;

  // Data memory read request
  typedef struct packed {
    logic        rd;   // Read strobe
    logic [15:0] addr; // Data address
  } oar_mem_s;

  // Immediate operand towards the execution unit
  typedef struct packed {
    logic        valid; // Immediate present
    logic [15:0] value; // Operand value
  } oar_opnd_s;

  localparam int unsigned N_AR = 8; // Auxiliary register count

  // Instruction word fields
  localparam int unsigned AMODE_BIT = 7; // 1 selects indirect
  localparam int unsigned DMA_HI = 6; // Direct offset top bit
  localparam int unsigned IND_LO = 4; // Indirect mode field low
  localparam int unsigned IND_HI = 6; // Indirect mode field high
  localparam int unsigned ARP_LD_BIT = 3; // Load new pointer
  localparam int unsigned ARP_HI = 2; // New pointer top bit
  localparam int unsigned IMM_HI = 7; // Short immediate top bit

  // Instruction lengths in program words
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

  // APB register byte offsets
  localparam logic [7:0] OFS_DP = 8'h00; // Data page pointer
  localparam logic [7:0] OFS_ARP = 8'h04; // Aux register pointer
  localparam logic [7:0] OFS_RPT = 8'h08; // Repeat status, read only
  localparam logic [7:0] OFS_AR0 = 8'h20; // First aux register
  localparam logic [7:0] OFS_AR7 = 8'h3c; // Last aux register
  localparam int unsigned RPT_ACT_BIT = 16; // Loop active flag

  // Reset values
  localparam logic [8:0] DP_RST = 9'h000;
  localparam logic [2:0] ARP_RST = 3'h0;
  localparam logic [15:0] AR_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;

endpackage : oar_pkg

// ---- logic/oar_ar_update.sv ----
/*
  Next-value unit for the selected auxiliary register under the
  indirect update modes, including reverse-carry arithmetic.
  Purely combinational; the caller registers the result.
*/
module oar_ar_update
  import oar_pkg::*;
(
  input  wire oar_ind_e    mode_i, // Update mode
  input  wire logic [15:0] ar_i,   // Current register value
  input  wire logic [15:0] idx_i,  // Index register value
  output logic [15:0]      ar_o    // Updated value
);

  logic [15:0] ar_rev; // Register, bits mirrored
  logic [15:0] idx_rev; // Index, bits mirrored
  logic [15:0] sum_rev; // Mirrored sum or difference
  logic [15:0] sum_fwd; // Sum mirrored back

  // Mirror per bit so that carries run from the top bit down
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_rev
      assign ar_rev[gi] = ar_i[15 - gi];
      assign idx_rev[gi] = idx_i[15 - gi];
      assign sum_fwd[gi] = sum_rev[15 - gi];
    end
  endgenerate

  // Mirrored add or subtract for the FFT modes
  always_comb begin
    if (mode_i == IND_BR_DEC) begin
      sum_rev = 16'(ar_rev - idx_rev);
    end else begin
      sum_rev = 16'(ar_rev + idx_rev);
    end
  end

  // Mode select
  always_comb begin
    unique case (mode_i)
      IND_NONE: ar_o = ar_i;
      IND_INC: ar_o = 16'(ar_i + 16'h0001);
      IND_DEC: ar_o = 16'(ar_i - 16'h0001);
      IND_ADD0: ar_o = 16'(ar_i + idx_i);
      IND_SUB0: ar_o = 16'(ar_i - idx_i);
      IND_BR_INC: ar_o = sum_fwd;
      IND_BR_DEC: ar_o = sum_fwd;
      IND_RSVD: ar_o = ar_i;
    endcase
  end

endmodule : oar_ar_update

// ---- tb/test_operand_addressing_repeat.sv ----
/*
  Self-checking bench for the operand addressing and repeat block.
  Drives the instruction port and the APB slave itself, with no model.
  Assumes the zero-wait APB answer and the one-cycle insn answer of oar_core.
*/
module test_operand_addressing_repeat;
  import oar_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i; // Core clock
  logic rst_n_i; // Synchronous reset, low
  oar_insn_s insn_i; // Instruction from fetch
  logic [15:0] data_rdata_i; // Data memory word
  oar_mem_s mem_o; // Data memory request
  oar_opnd_s opnd_o; // Immediate operand
  logic [1:0] insn_len_o; // Instruction length
  logic iter_o; // Iteration pulse
  logic fetch_hold_o; // Fetch hold
  logic irq_mask_o; // Interrupt mask
  logic psel_i, penable_i, pwrite_i; // APB controls
  logic [7:0] paddr_i; // APB address
  logic [31:0] pwdata_i; // APB write data
  logic [31:0] prdata_o; // APB read data
  logic pready_o, pslverr_o; // APB answer
  int n_errors; // Mismatches seen
  int n_checks; // Comparisons made
  logic [31:0] rd; // Last read word
  logic err; // Last slave error
  int n_it; // Iterations counted
  // Expected register after each indirect mode, AR1=0x18, index=8
  logic [15:0] exp_ar [8] = '{16'h0018, 16'h0019, 16'h0017, 16'h0020,
                              16'h0010, 16'h0014, 16'h0010, 16'h0018};

  oar_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .insn_i(insn_i),
    .data_rdata_i(data_rdata_i), .mem_o(mem_o), .opnd_o(opnd_o),
    .insn_len_o(insn_len_o), .iter_o(iter_o), .fetch_hold_o(fetch_hold_o),
    .irq_mask_o(irq_mask_o), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

  // Free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Single report point for pass, fail and hang
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One compare; four-state so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Synchronous reset held for five edges
  task automatic do_reset();
    @(posedge clk_i) rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask

  // APB transfer; waits for pready under a bound, data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i) penable_i <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      report_and_stop();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // One instruction for one cycle; returns once its answer has landed
  task automatic issue(input oar_kind_e k, input logic [15:0] w, input logic [15:0] w2);
    @(posedge clk_i) insn_i <= '{valid: 1'b1, kind: k, word: w, word2: w2};
    @(posedge clk_i) insn_i.valid <= 1'b0;
    #1;
  endtask

  // Feed repeatable work until fetch is released, counting iterations;
  // fetch only sees the release one edge late, so one more copy is taken
  task automatic run_loop();
    int i;
    n_it = 0;
    @(posedge clk_i) insn_i <= '{valid: 1'b1, kind: K_REPEATABLE, word: '0, word2: '0};
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      #1;
      n_it += (iter_o === 1'b1) ? 1 : 0;
      if (fetch_hold_o === 1'b0) break;
    end
    if (i == 40) begin
      n_errors++;
      report_and_stop();
    end
    @(posedge clk_i) insn_i.valid <= 1'b0;
    #1;
    chk(iter_o, 1'b0, "iteration after loop end");
  endtask

  // Hang guard, well over the cycle budget
  initial begin
    #500000;
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    n_checks = 0;
    rst_n_i = 1'b0;
    insn_i = '0;
    data_rdata_i = 16'h0001;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    do_reset();
    #1;
    chk(insn_len_o, LEN_ONE, "reset length");
    apb(1'b0, OFS_RPT, 32'h0); chk(rd, 32'h0, "reset count");
    apb(1'b0, OFS_ARP, 32'h0); chk(rd, 32'h0, "reset pointer");
    apb(1'b0, OFS_DP, 32'h0); chk(rd, 32'h0, "reset page");
    // Unmapped and read-only places refuse
    apb(1'b0, 8'h40, 32'h0); chk({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1'b1, OFS_RPT, 32'h5); chk(err, 1'b1, "status write");
    // Setup: page 5, pointer 1, index 8, AR2 0x55
    apb(1'b1, OFS_DP, 32'h5);
    apb(1'b1, OFS_ARP, 32'h1);
    apb(1'b1, OFS_AR0, 32'h8);
    apb(1'b1, OFS_AR0 + 8'h08, 32'h55);
    // Direct address is page then seven offset bits
    issue(K_MEM, 16'h0012, 16'h0);
    chk({mem_o.rd, mem_o.addr}, {1'b1, 16'h0292}, "direct address");
    // Every indirect mode, old value addressed, new value stored
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, OFS_AR0 + 8'h04, 32'h18);
      issue(K_MEM, {8'h00, 1'b1, 3'(m), 4'h0}, 16'h0);
      chk(mem_o.addr, 16'h0018, "indirect address");
      apb(1'b0, OFS_AR0 + 8'h04, 32'h0); chk(rd, {16'h0, exp_ar[m]}, "updated reg");
    end
    // Back to back increments see the first update
    @(posedge clk_i) insn_i <= '{valid: 1'b1, kind: K_MEM, word: 16'h0090, word2: 16'h0};
    @(posedge clk_i);
    #1;
    chk(mem_o.addr, 16'h0018, "first of pair");
    @(posedge clk_i) insn_i.valid <= 1'b0;
    #1;
    chk(mem_o.addr, 16'h0019, "second of pair");
    // Pointer reload after the access, next access uses AR2
    issue(K_MEM, 16'h008a, 16'h0);
    chk(mem_o.addr, 16'h001a, "reload address");
    apb(1'b0, OFS_ARP, 32'h0); chk(rd, 32'h2, "new pointer");
    issue(K_MEM, 16'h0080, 16'h0); chk(mem_o.addr, 16'h0055, "selected reg");
    // Immediate and register forms, lengths by form
    issue(K_SHORT, 16'h12a5, 16'h0);
    chk({opnd_o, 13'h0, insn_len_o}, {1'b1, 16'h00a5, 13'h0, 2'h1}, "short");
    issue(K_LONG, 16'h0000, 16'hbeef);
    chk({opnd_o, 13'h0, insn_len_o}, {1'b1, 16'hbeef, 13'h0, 2'h2}, "long");
    issue(K_REG, 16'h0000, 16'h0);
    chk({mem_o.rd, opnd_o.valid, insn_len_o}, 4'h1, "register form");
    // Repeat from short field: count 2 gives three runs, mask throughout
    issue(K_RPT_SHORT, 16'hff02, 16'h0);
    chk({fetch_hold_o, irq_mask_o}, 2'b11, "loop masked");
    apb(1'b0, OFS_RPT, 32'h0); chk(rd, 32'h0001_0002, "loaded count");
    run_loop();
    chk(n_it, 3, "short loop runs");
    chk(irq_mask_o, 1'b0, "mask released");
    apb(1'b0, OFS_RPT, 32'h0); chk(rd, 32'h0, "count at end");
    // Repeat from data word at page 5 offset 3, count 1
    issue(K_RPT_MEM, 16'h0003, 16'h0);
    chk({mem_o.rd, mem_o.addr}, {1'b1, 16'h0283}, "count fetch");
    run_loop();
    chk(n_it, 2, "memory loop runs");
    // Reset in mid-loop clears count and mask at once
    issue(K_RPT_SHORT, 16'h0005, 16'h0);
    do_reset();
    #1;
    chk({fetch_hold_o, irq_mask_o}, 2'b00, "reset in loop");
    apb(1'b0, OFS_RPT, 32'h0); chk(rd, 32'h0, "count cleared");
    report_and_stop();
  end
endmodule // test_operand_addressing_repeat
